// *** core/scr_ctrl_reg.sv ***
// serial link control register with management and configuration access
// What this block does
// - loopback bit set with on-chip transceiver loops transmit back internally.
// - ten-bit variant drives loopback bit straight onto the wrap pin.
// - with processor-system MAC both speed bits are read/write.
// - otherwise speed bits read 0 and 1 (1000 Mb/s), writes ignored.
// - auto-negotiation enable is read/write and resets to 1.
// - power-down bit puts the on-chip transceiver into low power.
// - power-down once set clears only through a core reset.
// - ten-bit variant stores power-down without any effect.
// - isolate bit is read/write, cuts client side, resets to 1.
// - restart auto-negotiation bit starts a restart and clears itself.
// - duplex bit always reads 1, writes ignored.
// - collision test bit always reads 0, writes ignored.
// - unidirectional bit allows transmit without link, read/write, resets 0.
// - five low bits are reserved, read zero, writes ignored.
// - register also loads from the configuration vector port.
// - any core reset source returns the register to defaults.
`timescale 1ns/1ps
module scr_ctrl_reg
  import scr_pkg::*;
#(
  parameter bit PS_MAC_MODE = 1'b0,
  parameter bit TBI_MODE = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_locked,
  // management serial pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n,
  input wire logic [4:0] phy_addr,
  // configuration vector
  input wire logic [15:0] cfg_vec,
  input wire logic cfg_vec_valid,
  // controls to the datapath
  output logic core_reset,
  output logic loopback_int,
  output logic ten_bit_interface_wrap,
  output logic [1:0] speed_sel,
  output logic an_enable,
  output logic an_restart,
  output logic power_down,
  output logic isolate,
  output logic unidir_enable
);
  scr_mgmt_if mbus ();

  scr_mdio_engine u_engine (
    .clk(clk),
    .rst(rst),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_n(mdio_oe_n),
    .phy_addr(phy_addr),
    .bus(mbus.engine)
  );

  logic lk_s1_q, lk_s2_q;
  logic soft_rst_q;
  logic core_rst_q;
  logic loop_q;
  logic spd_lsb_q;
  logic spd_msb_q;
  logic an_en_q;
  logic pdn_q;
  logic iso_q;
  logic an_rst_q;
  logic unidir_q;

  function automatic logic [15:0] scr_compose(input logic rs, input logic lp,
      input logic sl, input logic ae, input logic pd, input logic is,
      input logic ar, input logic sm, input logic ud);
    logic [15:0] w;
    w = 16'h0000;
    w[SCR_B_RESET] = rs;
    w[SCR_B_LOOP] = lp;
    w[SCR_B_SPD_LSB] = sl;
    w[SCR_B_AN_EN] = ae;
    w[SCR_B_PDN] = pd;
    w[SCR_B_ISO] = is;
    w[SCR_B_AN_RST] = ar;
    w[SCR_B_DUPLEX] = 1'b1;
    w[SCR_B_COLTEST] = 1'b0;
    w[SCR_B_SPD_MSB] = sm;
    w[SCR_B_UNIDIR] = ud;
    w[4:0] = SCR_RSVD_VAL;
    return w;
  endfunction

  // loss of clock lock arrives from outside the clock domain
  always_ff @(posedge clk) begin
    if (rst) begin
      lk_s1_q <= 1'b1;
      lk_s2_q <= 1'b1;
    end else begin
      lk_s1_q <= clk_locked;
      lk_s2_q <= lk_s1_q;
    end
  end

  // write source selection; a serial write wins over the vector
  wire mdio_wr = mbus.wr_stb && (mbus.reg_addr == SCR_CTRL_ADDR);
  wire wr_any = mdio_wr || cfg_vec_valid;
  wire [15:0] wr_val = mdio_wr ? mbus.wr_data : cfg_vec;
  wire any_rst = rst || !lk_s2_q || soft_rst_q;
  wire [15:0] rd_word = scr_compose(soft_rst_q, loop_q, spd_lsb_q, an_en_q,
    pdn_q, iso_q, an_rst_q, spd_msb_q, unidir_q);
  assign mbus.rd_data = (mbus.reg_addr == SCR_CTRL_ADDR) ? rd_word : 16'h0000;

  // next values of the stored fields
  wire soft_rst_d = wr_any && wr_val[SCR_B_RESET];
  wire loop_d = wr_any ? wr_val[SCR_B_LOOP] : loop_q;
  wire spd_lsb_d = (PS_MAC_MODE && wr_any) ? wr_val[SCR_B_SPD_LSB] : spd_lsb_q;
  wire spd_msb_d = (PS_MAC_MODE && wr_any) ? wr_val[SCR_B_SPD_MSB] : spd_msb_q;
  wire an_en_d = wr_any ? wr_val[SCR_B_AN_EN] : an_en_q;
  wire pdn_d = pdn_q || (wr_any && wr_val[SCR_B_PDN]);
  wire iso_d = wr_any ? wr_val[SCR_B_ISO] : iso_q;
  wire an_rst_d = wr_any && wr_val[SCR_B_AN_RST];
  wire unidir_d = wr_any ? wr_val[SCR_B_UNIDIR] : unidir_q;

  // register fields, returned to defaults by every reset source
  always_ff @(posedge clk) begin
    if (any_rst) begin
      soft_rst_q <= 1'b0;
      loop_q <= SCR_CTRL_RESET[SCR_B_LOOP];
      spd_lsb_q <= SCR_CTRL_RESET[SCR_B_SPD_LSB];
      spd_msb_q <= SCR_CTRL_RESET[SCR_B_SPD_MSB];
      an_en_q <= SCR_CTRL_RESET[SCR_B_AN_EN];
      pdn_q <= SCR_CTRL_RESET[SCR_B_PDN];
      iso_q <= SCR_CTRL_RESET[SCR_B_ISO];
      an_rst_q <= SCR_CTRL_RESET[SCR_B_AN_RST];
      unidir_q <= SCR_CTRL_RESET[SCR_B_UNIDIR];
    end else begin
      soft_rst_q <= soft_rst_d;
      loop_q <= loop_d;
      spd_lsb_q <= spd_lsb_d;
      spd_msb_q <= spd_msb_d;
      an_en_q <= an_en_d;
      pdn_q <= pdn_d;
      iso_q <= iso_d;
      an_rst_q <= an_rst_d;
      unidir_q <= unidir_d;
    end
  end

  // core reset output follows every reset source
  always_ff @(posedge clk) begin
    if (rst) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= any_rst;
    end
  end

  // controls to the datapath
  assign core_reset = core_rst_q;
  assign loopback_int = TBI_MODE ? 1'b0 : loop_q;
  assign ten_bit_interface_wrap = TBI_MODE ? loop_q : 1'b0;
  assign speed_sel = {spd_msb_q, spd_lsb_q};
  assign an_enable = an_en_q;
  assign an_restart = an_rst_q;
  assign power_down = TBI_MODE ? 1'b0 : pdn_q;
  assign isolate = iso_q;
  assign unidir_enable = unidir_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_soft_written;
    wr_any && wr_val[SCR_B_RESET] && !any_rst;
  endsequence

  sequence s_defaults_back;
    !soft_rst_q && iso_q && an_en_q && !pdn_q && !loop_q && !unidir_q;
  endsequence

  a_soft_reset_seq: assert property (s_soft_written |=> soft_rst_q ##1 s_defaults_back)
    else $error("soft reset did not pulse and restore defaults");
  a_defaults_after: assert property ($past(any_rst) |-> rd_word == SCR_CTRL_RESET)
    else $error("register not at default after reset");
  a_restart_pulse: assert property (wr_any && wr_val[SCR_B_AN_RST] && !any_rst
      |=> an_restart ##1 (!an_restart || $past(wr_any && wr_val[SCR_B_AN_RST])))
    else $error("restart bit not a single self clearing pulse");
  a_pdn_held: assert property (pdn_q && !any_rst |=> pdn_q)
    else $error("power down cleared without reset");
  a_fixed_bits: assert property (rd_word[SCR_B_DUPLEX] && !rd_word[SCR_B_COLTEST])
    else $error("duplex or collision test bit wrong");
  a_reserved_zero: assert property (rd_word[4:0] == SCR_RSVD_VAL)
    else $error("reserved bits not zero");
  a_speed_fixed: assert property (!PS_MAC_MODE |-> speed_sel == 2'h2)
    else $error("speed not fixed at 1000");
  a_speed_write: assert property (PS_MAC_MODE && wr_any && !any_rst
      |=> speed_sel == $past({wr_val[SCR_B_SPD_MSB], wr_val[SCR_B_SPD_LSB]}))
    else $error("speed bits did not take written value");
  a_iso_write: assert property (wr_any && !any_rst
      |=> isolate == $past(wr_val[SCR_B_ISO]) && unidir_enable == $past(wr_val[SCR_B_UNIDIR]))
    else $error("isolate or unidirectional bit did not follow write");
  a_loop_route: assert property (loopback_int == (loop_q && !TBI_MODE)
      && ten_bit_interface_wrap == (loop_q && TBI_MODE))
    else $error("loopback routing wrong");
  a_tbi_pdn: assert property (TBI_MODE |-> !power_down)
    else $error("power down acts in ten bit variant");
endmodule

// *** core/scr_mdio_engine.sv ***
// management serial frame engine: decodes read and write frames
`timescale 1ns/1ps
module scr_mdio_engine
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n,
  input wire logic [4:0] phy_addr,
  // register side
  scr_mgmt_if.engine bus
);
  logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
  logic dio_s1_q, dio_s2_q;
  logic [4:0] pa_s1_q, pa_s2_q;
  scr_mstate_t st_q;
  logic [5:0] ones_q;
  logic [4:0] cnt_q;
  logic [13:0] hdr_q;
  logic [15:0] sh_q;
  logic rd_q;
  logic wr_stb_q;
  logic [4:0] addr_q;
  logic [15:0] wdat_q;
  logic drv_o_q, drv_oe_n_q;
  wire rise = mdc_s2_q && !mdc_s3_q;
  wire bit_in = dio_s2_q;
  wire [13:0] hdr_new = {hdr_q[12:0], bit_in};
  wire hdr_ok = (hdr_new[13:12] == SCR_ST) && (hdr_new[9:5] == pa_s2_q) &&
    ((hdr_new[11:10] == SCR_OP_RD) || (hdr_new[11:10] == SCR_OP_WR));
  wire [15:0] sh_new = {sh_q[14:0], bit_in};

  // pin synchronisers
  always_ff @(posedge clk) begin
    mdc_s1_q <= mdc;
    mdc_s2_q <= mdc_s1_q;
    mdc_s3_q <= mdc_s2_q;
    dio_s1_q <= mdio_i;
    dio_s2_q <= dio_s1_q;
    pa_s1_q <= phy_addr;
    pa_s2_q <= pa_s1_q;
  end

  // frame sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= SCR_MS_PRE;
      ones_q <= 6'h00;
      cnt_q <= 5'h00;
      hdr_q <= 14'h0000;
      sh_q <= 16'h0000;
      rd_q <= 1'b0;
      wr_stb_q <= 1'b0;
      addr_q <= 5'h00;
      wdat_q <= 16'h0000;
      drv_o_q <= 1'b1;
      drv_oe_n_q <= 1'b1;
    end else begin
      wr_stb_q <= 1'b0;
      if (rise) begin
        case (st_q)
          SCR_MS_PRE: begin
            if (bit_in) begin
              if (ones_q != SCR_PRE_ONES) ones_q <= ones_q + 6'h01;
            end else if (ones_q == SCR_PRE_ONES) begin
              hdr_q <= 14'h0000;
              cnt_q <= 5'h01;
              st_q <= SCR_MS_HDR;
            end else begin
              ones_q <= 6'h00;
            end
          end
          SCR_MS_HDR: begin
            hdr_q <= hdr_new;
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == SCR_HDR_LAST) begin
              ones_q <= 6'h00;
              cnt_q <= 5'h00;
              rd_q <= hdr_new[11:10] == SCR_OP_RD;
              addr_q <= hdr_new[4:0];
              st_q <= hdr_ok ? SCR_MS_TA : SCR_MS_PRE;
            end
          end
          SCR_MS_TA: begin
            if (rd_q) begin
              drv_o_q <= 1'b0;
              drv_oe_n_q <= 1'b0;
              sh_q <= bus.rd_data;
              st_q <= SCR_MS_DATA;
            end else if (cnt_q == 5'h01) begin
              cnt_q <= 5'h00;
              st_q <= SCR_MS_DATA;
            end else begin
              cnt_q <= 5'h01;
            end
          end
          SCR_MS_DATA: begin
            cnt_q <= cnt_q + 5'h01;
            if (rd_q) begin
              drv_o_q <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'b0};
              if (cnt_q == SCR_DATA_END) begin
                drv_o_q <= 1'b1;
                drv_oe_n_q <= 1'b1;
                st_q <= SCR_MS_PRE;
              end
            end else begin
              sh_q <= sh_new;
              if (cnt_q == SCR_DATA_LAST) begin
                wdat_q <= sh_new;
                wr_stb_q <= 1'b1;
                st_q <= SCR_MS_PRE;
              end
            end
          end
          default: st_q <= SCR_MS_PRE;
        endcase
      end
    end
  end

  assign bus.wr_stb = wr_stb_q;
  assign bus.reg_addr = addr_q;
  assign bus.wr_data = wdat_q;
  assign mdio_o = drv_o_q;
  assign mdio_oe_n = drv_oe_n_q;
endmodule

// *** shared/scr_mgmt_if.sv ***
// register access signals between the serial frame engine and the register
`timescale 1ns/1ps
interface scr_mgmt_if;
  logic wr_stb;
  logic [4:0] reg_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  modport engine (output wr_stb, output reg_addr, output wr_data, input rd_data);
  modport regs (input wr_stb, input reg_addr, input wr_data, output rd_data);
endinterface

// *** shared/scr_pkg.sv ***
// constants and types for the serial link control register block
package scr_pkg;
  // register map
  localparam logic [4:0] SCR_CTRL_ADDR = 5'h00;
  localparam logic [15:0] SCR_CTRL_RESET = 16'h1540;
  localparam int SCR_B_RESET = 15;
  localparam int SCR_B_LOOP = 14;
  localparam int SCR_B_SPD_LSB = 13;
  localparam int SCR_B_AN_EN = 12;
  localparam int SCR_B_PDN = 11;
  localparam int SCR_B_ISO = 10;
  localparam int SCR_B_AN_RST = 9;
  localparam int SCR_B_DUPLEX = 8;
  localparam int SCR_B_COLTEST = 7;
  localparam int SCR_B_SPD_MSB = 6;
  localparam int SCR_B_UNIDIR = 5;
  localparam logic [4:0] SCR_RSVD_VAL = 5'h00;
  // management frame format
  localparam logic [5:0] SCR_PRE_ONES = 6'h20;
  localparam logic [1:0] SCR_ST = 2'h1;
  localparam logic [1:0] SCR_OP_WR = 2'h1;
  localparam logic [1:0] SCR_OP_RD = 2'h2;
  localparam logic [4:0] SCR_HDR_LAST = 5'h0D;
  localparam logic [4:0] SCR_DATA_LAST = 5'h0F;
  localparam logic [4:0] SCR_DATA_END = 5'h10;
  typedef enum logic [3:0] {
    SCR_MS_PRE = 4'b0001,
    SCR_MS_HDR = 4'b0010,
    SCR_MS_TA = 4'b0100,
    SCR_MS_DATA = 4'b1000
  } scr_mstate_t;
endpackage

// *** tb/scr_mdio_mgr.sv ***
// management station model driving clause 22 frames on the serial pins
`timescale 1ns/1ps
module scr_mdio_mgr
  import scr_pkg::*;
(
  // clock
  input wire logic clk,
  // management pins
  output logic mdc,
  output logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_n,
  // read results
  output logic rd_done,
  output logic [15:0] rd_word
);
  // mdc half period in clk cycles, keeps mdc at 2.5 MHz
  localparam int HALF = 50;
  logic drv_en;
  logic drv_bit;
  // line has a pull-up: released by both parties it reads 1
  assign mdio_i = !mdio_oe_n ? mdio_o : (drv_en ? drv_bit : 1'b1);
  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv_bit = 1'b1;
    rd_done = 1'b0;
    rd_word = 16'h0000;
  end
  // one full frame with its own preamble; mdc stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, SCR_ST, op, pa, ra, 2'b10, wd};
    for (int i = 0; i < 64; i++) begin
      drv_en = (op == SCR_OP_WR) || (i < 46);
      drv_bit = bits[63 - i];
      repeat (HALF) @(negedge clk);
      // the device launches each bit after the previous rise, so sample before this rise
      if (op == SCR_OP_RD && i >= 48) begin
        rd_word[63 - i] = mdio_i;
      end
      mdc = 1'b1;
      repeat (HALF) @(negedge clk);
      mdc = 1'b0;
    end
    drv_en = 1'b0;
    if (op == SCR_OP_RD) begin
      rd_done = 1'b1;
      @(negedge clk);
      rd_done = 1'b0;
    end
  endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking testbench for the serial link control register
`timescale 1ns/1ps
module tb_top;
  import scr_pkg::*;
  logic clk, rst, clk_locked, mdc, mdio_i, mdio_o, mdio_oe_n, cfg_vec_valid, rd_done;
  logic [4:0] phy_addr;
  logic [15:0] cfg_vec, rd_word;
  logic core_reset, loopback_int, wrap_a, an_restart, power_down, isolate, unidir_enable;
  logic an_enable, loop_b, wrap_b, pdn_b;
  logic [1:0] speed_sel, speed_b;
  logic [15:0] exp_q[$];
  int fails, num_checks;
  int cyc = 0;

  scr_ctrl_reg scr_ctrl_reg_inst (.clk(clk), .rst(rst), .clk_locked(clk_locked), .mdc(mdc),
    .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .phy_addr(phy_addr),
    .cfg_vec(cfg_vec), .cfg_vec_valid(cfg_vec_valid), .core_reset(core_reset),
    .loopback_int(loopback_int), .ten_bit_interface_wrap(wrap_a), .speed_sel(speed_sel),
    .an_enable(an_enable), .an_restart(an_restart), .power_down(power_down),
    .isolate(isolate), .unidir_enable(unidir_enable));
  // ten-bit variant paired with the processor-system mac, never addressed serially
  scr_ctrl_reg #(.PS_MAC_MODE(1'b1), .TBI_MODE(1'b1)) scr_ctrl_reg_inst_b (.clk(clk),
    .rst(rst), .clk_locked(clk_locked), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(),
    .mdio_oe_n(), .phy_addr(~phy_addr), .cfg_vec(cfg_vec), .cfg_vec_valid(cfg_vec_valid),
    .core_reset(), .loopback_int(loop_b), .ten_bit_interface_wrap(wrap_b),
    .speed_sel(speed_b), .an_enable(), .an_restart(), .power_down(pdn_b), .isolate(),
    .unidir_enable());
  scr_mdio_mgr scr_mdio_mgr_inst (.clk(clk), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe_n(mdio_oe_n), .rd_done(rd_done), .rd_word(rd_word));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk_out(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_word(input logic [15:0] exp, input logic [15:0] got);
    chk_out("read word", exp, got);
  endtask

  // packed view of the main datapath controls
  function automatic logic [15:0] outs();
    return {6'h00, wrap_a, loopback_int, an_enable, power_down, isolate, unidir_enable, an_restart,
            speed_sel, core_reset};
  endfunction

  function automatic logic [15:0] outs_b();
    return {11'h000, wrap_b, loop_b, pdn_b, speed_b};
  endfunction

  // readback expected for a plain-mode word with sticky power-down pd
  function automatic logic [15:0] exp_rd(input logic [15:0] w, input logic pd);
    return {1'b0, w[14], 1'b0, w[12], pd | w[11], w[10], 3'b010, 1'b1, w[5], 5'h00};
  endfunction

  task automatic rd_frame(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
    exp_q.push_back(e);
    scr_mdio_mgr_inst.frame(SCR_OP_RD, pa, ra, 16'h0000);
  endtask

  task automatic cfg_write(input logic [15:0] w);
    @(negedge clk);
    cfg_vec = w;
    cfg_vec_valid = 1'b1;
    @(negedge clk);
    cfg_vec_valid = 1'b0;
  endtask

  // monitor: each finished read is compared with the oldest note
  always @(posedge rd_done) begin
    if (exp_q.size() == 0) begin
      fails++;
      $display("mismatch read queue expected note seen none");
    end else begin
      chk_word(exp_q.pop_front(), rd_word);
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    logic [15:0] w;
    logic [15:0] w2;
    fails = 0;
    num_checks = 0;
    void'($urandom(7));
    rst = 1'b1;
    clk_locked = 1'b1;
    cfg_vec = 16'h0000;
    cfg_vec_valid = 1'b0;
    phy_addr = 5'($urandom());
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_out("defaults", 16'h00A4, outs());
    rd_frame(phy_addr, SCR_CTRL_ADDR, 16'h1540);
    w = (16'($urandom()) & 16'h7DFF) | 16'h0800;
    scr_mdio_mgr_inst.frame(SCR_OP_WR, phy_addr, SCR_CTRL_ADDR, w);
    repeat (8) @(negedge clk);
    chk_out("write outs", {7'h00, w[14], w[12], 1'b1, w[10], w[5], 4'h4}, outs());
    rd_frame(phy_addr, SCR_CTRL_ADDR, exp_rd(w, 1'b1));
    w2 = 16'($urandom()) & 16'h75FF;
    scr_mdio_mgr_inst.frame(SCR_OP_WR, phy_addr, SCR_CTRL_ADDR, w2);
    rd_frame(phy_addr, SCR_CTRL_ADDR, exp_rd(w2, 1'b1));
    rd_frame(phy_addr ^ 5'h01, SCR_CTRL_ADDR, 16'hFFFF);
    rd_frame(phy_addr, 5'h01, 16'h0000);
    w = (16'($urandom()) & 16'h7DFF) | 16'h0A00;
    cfg_write(w);
    chk_out("cfg outs", {7'h00, w[14], w[12], 1'b1, w[10], w[5], 4'hC}, outs());
    chk_out("cfg outs b", {11'h000, w[14], 2'b00, w[6], w[13]}, outs_b());
    @(negedge clk);
    chk_out("restart clear", 16'h0000, {15'h0000, an_restart});
    cfg_write(16'h8000);
    @(negedge clk);
    chk_out("core reset", 16'h0001, {15'h0000, core_reset});
    repeat (2) @(negedge clk);
    chk_out("soft reset", 16'h00A4, outs());
    chk_out("soft reset b", 16'h0002, outs_b());
    rd_frame(phy_addr, SCR_CTRL_ADDR, 16'h1540);
    cfg_write(16'h4020);
    chk_out("cfg loop", 16'h0114, outs());
    chk_out("cfg loop b", 16'h0010, outs_b());
    clk_locked = 1'b0;
    repeat (3) @(negedge clk);
    clk_locked = 1'b1;
    repeat (6) @(negedge clk);
    chk_out("lock loss", 16'h00A4, outs());
    finish_test();
  end
endmodule
